// File: rtl/acgp_channel_cfg.v
`timescale 1ns/1ps
`include "acgp_defs.vh"
// How it works
// - volume code 1 gives -80 dB, each further code adds 0.5 dB.
// - volume code zero mutes the channel output entirely.
// - volume code 161 is unity gain and is the reset value.
// - volume code 255 gives +47 dB.
// - trim field bits 7..4: -0.8 dB at code 0, +0.1 dB per step.
// - trim resets to code 8, 0 dB; code 15 gives +0.7 dB.
// - delay field bits 7..2 delays the channel 0 to 63 modulator cycles.
// - channel 3 copy bit makes its filter input equal channel 1 input.
// - channel 4 copy bit makes its filter input equal channel 2 input.
// - channel 2 coupling bits 3..2 pick codes 0..2; code 3 reserved.
// - channel 2 range bit: clear 10 Vrms, set 5 Vrms.
// - channel 2 band bit: clear 24 kHz, set 96 kHz, 40 kOhm only.
module acgp_channel_cfg (
  input wire core_clk,
  input wire nrst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_hit,
  input wire mod_valid,
  input wire signed [`ACGP_DW-1:0] mod1_sample,
  input wire signed [`ACGP_DW-1:0] mod2_sample,
  input wire signed [`ACGP_DW-1:0] mod3_sample,
  input wire signed [`ACGP_DW-1:0] mod4_sample,
  output wire [2:0] out_valid,
  output wire signed [`ACGP_DW-1:0] chan2_sample,
  output wire signed [`ACGP_DW-1:0] chan3_sample,
  output wire signed [`ACGP_DW-1:0] chan4_sample,
  output wire [1:0] chan2_coupling_sel,
  output wire chan2_range_sel,
  output wire chan2_band_sel
);
  // ***************************************************
  // register file
  // ***************************************************
  reg [7:0] adc2_input_setup_reg;
  reg [7:0] vol_reg [0:2];
  reg [3:0] trim_reg [0:2];
  reg [5:0] dly_reg [0:2];
  reg chan3_copy_input_reg;
  reg chan4_copy_input_reg;
  wire [7:0] setup_wmask = reg_wdata & `ACGP_MASK_SETUP;
  // writes keep only writable bits, so reserved bits stay zero
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      adc2_input_setup_reg <= `ACGP_RST_ZERO8;
      vol_reg[0] <= `ACGP_RST_VOL;
      vol_reg[1] <= `ACGP_RST_VOL;
      vol_reg[2] <= `ACGP_RST_VOL;
      trim_reg[0] <= `ACGP_RST_FINE;
      trim_reg[1] <= `ACGP_RST_FINE;
      trim_reg[2] <= `ACGP_RST_FINE;
      dly_reg[0] <= 6'h00;
      dly_reg[1] <= 6'h00;
      dly_reg[2] <= 6'h00;
      chan3_copy_input_reg <= 1'b0;
      chan4_copy_input_reg <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `ACGP_ADDR_CH2_SETUP: begin
          // reserved coupling code is refused; the field keeps its value
          if (setup_wmask[3:2] == `ACGP_CPL_RSVD) begin
            adc2_input_setup_reg <= {setup_wmask[7:4], adc2_input_setup_reg[3:2],
                                     setup_wmask[1:0]};
          end else begin
            adc2_input_setup_reg <= setup_wmask;
          end
        end
        `ACGP_ADDR_CH2_VOL: vol_reg[0] <= reg_wdata;
        `ACGP_ADDR_CH2_FINE: trim_reg[0] <= reg_wdata[7:4];
        `ACGP_ADDR_CH2_PHASE: dly_reg[0] <= reg_wdata[7:2];
        `ACGP_ADDR_CH3_COPY: chan3_copy_input_reg <= reg_wdata[7];
        `ACGP_ADDR_CH3_VOL: vol_reg[1] <= reg_wdata;
        `ACGP_ADDR_CH3_FINE: trim_reg[1] <= reg_wdata[7:4];
        `ACGP_ADDR_CH3_PHASE: dly_reg[1] <= reg_wdata[7:2];
        `ACGP_ADDR_CH4_COPY: chan4_copy_input_reg <= reg_wdata[7];
        `ACGP_ADDR_CH4_VOL: vol_reg[2] <= reg_wdata;
        `ACGP_ADDR_CH4_FINE: trim_reg[2] <= reg_wdata[7:4];
        `ACGP_ADDR_CH4_PHASE: dly_reg[2] <= reg_wdata[7:2];
        default: begin
        end
      endcase
    end
  end
  // ***************************************************
  // read back
  // ***************************************************
  // registered read data; unmapped addresses read zero with hit low
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end else if (reg_rd) begin
      reg_hit <= 1'b1;
      case (reg_addr)
        `ACGP_ADDR_CH2_SETUP: reg_rdata <= adc2_input_setup_reg;
        `ACGP_ADDR_CH2_VOL: reg_rdata <= vol_reg[0];
        `ACGP_ADDR_CH2_FINE: reg_rdata <= {trim_reg[0], 4'h0};
        `ACGP_ADDR_CH2_PHASE: reg_rdata <= {dly_reg[0], 2'h0};
        `ACGP_ADDR_CH3_COPY: reg_rdata <= {chan3_copy_input_reg, 7'h00};
        `ACGP_ADDR_CH3_VOL: reg_rdata <= vol_reg[1];
        `ACGP_ADDR_CH3_FINE: reg_rdata <= {trim_reg[1], 4'h0};
        `ACGP_ADDR_CH3_PHASE: reg_rdata <= {dly_reg[1], 2'h0};
        `ACGP_ADDR_CH4_COPY: reg_rdata <= {chan4_copy_input_reg, 7'h00};
        `ACGP_ADDR_CH4_VOL: reg_rdata <= vol_reg[2];
        `ACGP_ADDR_CH4_FINE: reg_rdata <= {trim_reg[2], 4'h0};
        `ACGP_ADDR_CH4_PHASE: reg_rdata <= {dly_reg[2], 2'h0};
        default: begin
          reg_rdata <= 8'h00;
          reg_hit <= 1'b0;
        end
      endcase
    end else begin
      reg_hit <= 1'b0;
    end
  end
  // ***************************************************
  // analog front-end controls for channel 2
  // ***************************************************
  // these steer the analog path outside; band select only meaningful at 40 kOhm
  assign chan2_coupling_sel = adc2_input_setup_reg[3:2];
  assign chan2_range_sel = adc2_input_setup_reg[1];
  assign chan2_band_sel = adc2_input_setup_reg[0];
  // ***************************************************
  // filter input selection and gain stages
  // ***************************************************
  // copy bits pick another channel's modulator stream, else own input
  wire signed [`ACGP_DW-1:0] src3 = chan3_copy_input_reg ? mod1_sample : mod3_sample;
  wire signed [`ACGP_DW-1:0] src4 = chan4_copy_input_reg ? mod2_sample : mod4_sample;
  wire signed [`ACGP_DW-1:0] src [0:2];
  wire signed [`ACGP_DW-1:0] res [0:2];
  assign src[0] = mod2_sample;
  assign src[1] = src3;
  assign src[2] = src4;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_ch
      acgp_gain_stage u_stage (
        .core_clk(core_clk),
        .nrst(nrst),
        .mod_valid(mod_valid),
        .mod_sample(src[g]),
        .volume_code(vol_reg[g]),
        .trim_gain(trim_reg[g]),
        .delay_trim(dly_reg[g]),
        .out_valid(out_valid[g]),
        .out_sample(res[g])
      );
    end
  endgenerate
  assign chan2_sample = res[0];
  assign chan3_sample = res[1];
  assign chan4_sample = res[2];
endmodule

// File: rtl/acgp_defs.vh
`ifndef ACGP_DEFS_VH
`define ACGP_DEFS_VH
// register byte offsets
`define ACGP_ADDR_CH2_SETUP 8'h55
`define ACGP_ADDR_CH2_VOL 8'h57
`define ACGP_ADDR_CH2_FINE 8'h58
`define ACGP_ADDR_CH2_PHASE 8'h59
`define ACGP_ADDR_CH3_COPY 8'h5a
`define ACGP_ADDR_CH3_VOL 8'h5b
`define ACGP_ADDR_CH3_FINE 8'h5c
`define ACGP_ADDR_CH3_PHASE 8'h5d
`define ACGP_ADDR_CH4_COPY 8'h5e
`define ACGP_ADDR_CH4_VOL 8'h5f
`define ACGP_ADDR_CH4_FINE 8'h60
`define ACGP_ADDR_CH4_PHASE 8'h61
// reset values
`define ACGP_RST_VOL 8'ha1
`define ACGP_RST_FINE 4'h8
`define ACGP_RST_ZERO8 8'h00
// writable masks
`define ACGP_MASK_SETUP 8'hcf
`define ACGP_MASK_FINE 8'hf0
`define ACGP_MASK_PHASE 8'hfc
`define ACGP_MASK_COPY 8'h80
// coupling reserved code
`define ACGP_CPL_RSVD 2'h3
// volume: code 161 is 0 dB, 0 is mute; gain table q1.15 for 0..+5.5 dB in 0.5 dB
`define ACGP_VOL_UNITY 8'ha1
`define ACGP_VOL_MUTE 8'h00
`define ACGP_STEPS_PER_6DB 8'h0c
`define ACGP_FINE_UNITY 4'h8
// fraction bits carried by the two q1.15 mantissa products
`define ACGP_PROD_FRAC 7'd30
// sample width and delay pointer width
`define ACGP_DW 24
`define ACGP_PW 6
`endif

// File: rtl/acgp_gain_stage.v
`timescale 1ns/1ps
`include "acgp_defs.vh"
// one channel: phase delay line, volume and trim multiply with saturation
module acgp_gain_stage (
  input wire core_clk,
  input wire nrst,
  input wire mod_valid,
  input wire signed [`ACGP_DW-1:0] mod_sample,
  input wire [7:0] volume_code,
  input wire [3:0] trim_gain,
  input wire [`ACGP_PW-1:0] delay_trim,
  output reg out_valid,
  output reg signed [`ACGP_DW-1:0] out_sample
);
  // ***************************************************
  // phase delay line
  // ***************************************************
  reg signed [`ACGP_DW-1:0] dly_mem [0:63];
  reg [`ACGP_PW-1:0] wr_ptr_reg;
  integer i;
  // write each modulator sample; read delay_trim entries back, code 0 is direct
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= {`ACGP_PW{1'b0}};
      for (i = 0; i < 64; i = i + 1) begin
        dly_mem[i] <= {`ACGP_DW{1'b0}};
      end
    end else if (mod_valid) begin
      dly_mem[wr_ptr_reg] <= mod_sample;
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end
  wire [`ACGP_PW-1:0] rd_idx = wr_ptr_reg - delay_trim;
  wire signed [`ACGP_DW-1:0] dly_sample;
  assign dly_sample = (delay_trim == {`ACGP_PW{1'b0}}) ? mod_sample : dly_mem[rd_idx];
  // ***************************************************
  // gain factors
  // ***************************************************
  // volume: offset from unity in 0.5 dB steps, split into 6 dB shifts and a fraction
  wire signed [9:0] vol_off = $signed({2'b00, volume_code}) - $signed({2'b00, `ACGP_VOL_UNITY});
  reg signed [5:0] shift6;
  reg [3:0] frac;
  reg [15:0] vol_mant;
  reg [15:0] corr_mant;
  reg [15:0] fine_mant;
  reg signed [9:0] tmp;
  reg signed [9:0] quo;
  // floor division by 12 so every half-dB step is uniform
  always @* begin
    tmp = vol_off;
    if (tmp >= 0) begin
      quo = tmp / 10'sd12;
    end else begin
      quo = -((-tmp + 10'sd11) / 10'sd12);
    end
    shift6 = quo[5:0];
    frac = tmp[3:0] - (shift6[3:0] * 4'd12);
    // 10^(k*0.5/20), 0x8000 is unity, k = 0..11
    case (frac)
      4'h0: vol_mant = 16'h8000;
      4'h1: vol_mant = 16'h8796;
      4'h2: vol_mant = 16'h8f9e;
      4'h3: vol_mant = 16'h9821;
      4'h4: vol_mant = 16'ha124;
      4'h5: vol_mant = 16'haab1;
      4'h6: vol_mant = 16'hb4ce;
      4'h7: vol_mant = 16'hbf85;
      4'h8: vol_mant = 16'hcade;
      4'h9: vol_mant = 16'hd6e3;
      4'ha: vol_mant = 16'he39f;
      4'hb: vol_mant = 16'hf11b;
      default: vol_mant = 16'h8000;
    endcase
    // twelve half-dB steps are 6 dB but an octave shift is 6.02 dB; without this trim the
    // error piles up to about 0.29 dB at the quiet end
    case (shift6)
      6'h32: corr_mant = 16'h8452;
      6'h33: corr_mant = 16'h8402;
      6'h34: corr_mant = 16'h83b2;
      6'h35: corr_mant = 16'h8362;
      6'h36: corr_mant = 16'h8312;
      6'h37: corr_mant = 16'h82c3;
      6'h38: corr_mant = 16'h8274;
      6'h39: corr_mant = 16'h8225;
      6'h3a: corr_mant = 16'h81d6;
      6'h3b: corr_mant = 16'h8187;
      6'h3c: corr_mant = 16'h8138;
      6'h3d: corr_mant = 16'h80ea;
      6'h3e: corr_mant = 16'h809c;
      6'h3f: corr_mant = 16'h804e;
      6'h01: corr_mant = 16'h7fb2;
      6'h02: corr_mant = 16'h7f65;
      6'h03: corr_mant = 16'h7f18;
      6'h04: corr_mant = 16'h7ecb;
      6'h05: corr_mant = 16'h7e7e;
      6'h06: corr_mant = 16'h7e31;
      6'h07: corr_mant = 16'h7de4;
      default: corr_mant = 16'h8000;
    endcase
    // trim: -0.8 dB at 0, 0.1 dB per code, unity at 8 0x8000 is unity
    case (trim_gain)
      4'h0: fine_mant = 16'h74bd;
      4'h1: fine_mant = 16'h7617;
      4'h2: fine_mant = 16'h7775;
      4'h3: fine_mant = 16'h78d7;
      4'h4: fine_mant = 16'h7a3d;
      4'h5: fine_mant = 16'h7ba8;
      4'h6: fine_mant = 16'h7d16;
      4'h7: fine_mant = 16'h7e89;
      4'h8: fine_mant = 16'h8000;
      4'h9: fine_mant = 16'h817b;
      4'ha: fine_mant = 16'h82fb;
      4'hb: fine_mant = 16'h8480;
      4'hc: fine_mant = 16'h8608;
      4'hd: fine_mant = 16'h8796;
      4'he: fine_mant = 16'h8928;
      default: fine_mant = 16'h8abe;
    endcase
  end
  // ***************************************************
  // multiply and saturate
  // ***************************************************
  // both factors multiplied on each sample; mantissas are q1.15 against 0x8000 unity
  // trimmed volume mantissa; the raw product stays below 2^31 for every code
  wire [31:0] vol_full = vol_mant * corr_mant;
  wire [15:0] vol_eff = vol_full[30:15];
  wire signed [`ACGP_DW+16:0] p1 = dly_sample * $signed({1'b0, vol_eff});
  wire signed [`ACGP_DW+33:0] p2 = p1 * $signed({1'b0, fine_mant});
  // one shift drops the fraction and applies the octave, so only one floor is taken
  wire [6:0] sh_amt = `ACGP_PROD_FRAC - {shift6[5], shift6};
  wire signed [`ACGP_DW+33:0] scaled = p2 >>> sh_amt;
  localparam signed [`ACGP_DW+33:0] SAT_HI = (58'sd1 <<< (`ACGP_DW-1)) - 58'sd1;
  localparam signed [`ACGP_DW+33:0] SAT_LO = -(58'sd1 <<< (`ACGP_DW-1));
  // clamp rather than wrap, so +47 dB cannot fold a loud sample
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_sample <= {`ACGP_DW{1'b0}};
    end else begin
      out_valid <= mod_valid;
      if (!mod_valid) out_sample <= out_sample;
      else if (volume_code == `ACGP_VOL_MUTE) out_sample <= {`ACGP_DW{1'b0}};
      else if (scaled > SAT_HI) out_sample <= SAT_HI[`ACGP_DW-1:0];
      else if (scaled < SAT_LO) out_sample <= SAT_LO[`ACGP_DW-1:0];
      else out_sample <= scaled[`ACGP_DW-1:0];
    end
  end
endmodule

// File: verification/acgp_monitor.sv
`timescale 1ns/1ps
// ********************************
// port checker for the channel block
// ********************************
module acgp_monitor (
  input logic core_clk,
  input logic nrst,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic reg_hit,
  input logic mod_valid,
  input logic [2:0] out_valid,
  input logic signed [23:0] chan2_sample,
  input logic [1:0] chan2_coupling_sel,
  input logic chan2_range_sel,
  input logic chan2_band_sel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // decode helpers; 0x56 is the only hole inside the map
  wire mapped = reg_addr == 8'h55 || (reg_addr >= 8'h57 && reg_addr <= 8'h61);
  wire wr_setup = reg_wr && reg_addr == 8'h55;
  valid_follow_a: assert property (mod_valid |=> out_valid == 3'h7)
    else $error("out_valid missed a strobe");
  valid_idle_a: assert property (!mod_valid |=> out_valid == 3'h0)
    else $error("out_valid without a strobe");
  sample_hold_a: assert property (!mod_valid |=> $stable(chan2_sample))
    else $error("chan2 sample moved without a strobe");
  hit_mapped_a: assert property (reg_rd && mapped |=> reg_hit)
    else $error("mapped read gave no hit");
  hole_read_a: assert property (reg_rd && !mapped |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read answered");
  rsvd_zero_a: assert property (reg_rd && reg_addr == 8'h58 |=> reg_rdata[3:0] == 4'h0)
    else $error("reserved trim bits read nonzero");
  cpl_refuse_a: assert property (wr_setup && reg_wdata[3:2] == 2'h3 |=>
    $stable(chan2_coupling_sel)) else $error("reserved coupling code taken");
  cpl_take_a: assert property (wr_setup && reg_wdata[3:2] != 2'h3 |=>
    chan2_coupling_sel == $past(reg_wdata[3:2])) else $error("coupling not taken");
  range_band_a: assert property (wr_setup |=>
    {chan2_range_sel, chan2_band_sel} == $past(reg_wdata[1:0])) else $error("range or band");
endmodule

// File: verification/adc_channel_gain_phase_config_tb.sv
`timescale 1ns/1ps
// ********************************
// self-checking bench
// ********************************
module adc_channel_gain_phase_config_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic mod_valid = 1'b0;
  logic signed [23:0] m1 = 24'h0, m2 = 24'h0, m3 = 24'h0, m4 = 24'h0;
  wire [7:0] reg_rdata;
  wire reg_hit;
  wire [2:0] out_valid;
  wire signed [23:0] c2, c3, c4;
  wire [1:0] cpl;
  wire rng, bnd;
  logic [7:0] mdl [0:255];
  logic signed [23:0] hist [$];
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #50 core_clk = ~core_clk;
  acgp_channel_cfg dut (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .mod_valid(mod_valid), .mod1_sample(m1), .mod2_sample(m2), .mod3_sample(m3),
    .mod4_sample(m4), .out_valid(out_valid), .chan2_sample(c2), .chan3_sample(c3),
    .chan4_sample(c4), .chan2_coupling_sel(cpl), .chan2_range_sel(rng), .chan2_band_sel(bnd));
  // writable bits per offset; zero means unmapped
  function automatic logic [7:0] msk(input logic [7:0] a);
    logic [1:0] k;
    k = a - 8'h57;
    if (a == 8'h55) msk = 8'hcf;
    else if (a < 8'h57 || a > 8'h61) msk = 8'h00;
    else msk = k == 0 ? 8'hff : k == 1 ? 8'hf0 : k == 2 ? 8'hfc : 8'h80;
  endfunction
  // linear gain of a volume and trim pair
  function automatic real gain(input int v, input int t);
    gain = 10.0 ** ((0.5 * v - 80.5 + 0.1 * t - 0.8) / 20.0);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // register tasks idle a cycle at the end so strobes never toggle twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {mod_valid, reg_wr, reg_addr, reg_wdata} = {1'b0, 1'b1, a, d};
    @(posedge core_clk);
    #1 reg_wr = 1'b0;
    mdl[a] = (a == 8'h55 && d[3:2] == 2'h3) ? (d & 8'hc3) | (mdl[a] & 8'h0c) : d & msk(a);
    @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    {mod_valid, reg_rd, reg_addr} = {1'b0, 1'b1, a};
    @(posedge core_clk);
    #1 reg_rd = 1'b0;
    chk("reg_rdata", reg_rdata, mdl[a]);
    chk("reg_hit", reg_hit, msk(a) != 0);
    @(posedge core_clk);
    #1;
  endtask
  // one strobe; valid stays high so samples can follow back to back
  task automatic smp(input logic signed [23:0] a, input logic signed [23:0] b);
    {mod_valid, m1, m2, m3, m4} = {1'b1, a, b, ~a, ~b};
    hist.push_back(b);
    @(posedge core_clk);
    #1;
    chk("out_valid", out_valid, 3'h7);
  endtask
  task automatic gchk(input int v, input int t, input logic signed [23:0] x);
    real e;
    wr(8'h57, v);
    wr(8'h58, t << 4);
    wr(8'h5b, v);
    wr(8'h5c, t << 4);
    smp(x, x);
    e = v ? x * gain(v, t) : 0.0;
    if (e > 8388607.0) e = 8388607.0;
    if (e < -8388608.0) e = -8388608.0;
    chk("chan2 gain", (c2 - e) ** 2 <= 4.0 + (e * 0.003) ** 2 && !$isunknown(c2), 1'b1);
    chk("chan3 gain", (c3 - e) ** 2 <= 4.0 + (e * 0.003) ** 2 && !$isunknown(c3), 1'b1);
  endtask
  // hang guard, the run needs under two thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      complete_run;
    end
  end
  int vt [10] = '{0, 1, 2, 161, 162, 254, 255, 255, 100, 161};
  int tt [10] = '{8, 8, 0, 8, 15, 8, 15, 8, 0, 15};
  initial begin
    void'($urandom(32'h351d));
    for (int a = 0; a < 256; a++) mdl[a] = msk(a) == 8'hff ? 8'ha1 : msk(a) == 8'hf0 ? 8'h80 : 0;
    repeat (3) @(posedge core_clk);
    #1 nrst = 1'b1;
    for (int a = 8'h55; a <= 8'h62; a++) rd(a);
    wr(8'h55, 8'h8e);
    wr(8'h55, 8'h49);
    wr(8'h55, 8'h8d);
    rd(8'h55);
    repeat (60) begin
      int a;
      a = 8'h54 + $urandom % 15;
      wr(a, $urandom & msk(a));
      rd(a);
      chk("coupling pins", {cpl, rng, bnd}, mdl[8'h55][3:0]);
    end
    for (int c = 0; c < 3; c++) begin
      wr(8'h57 + 4 * c, 8'ha1);
      wr(8'h58 + 4 * c, 8'h80);
      wr(8'h59 + 4 * c, 8'h00);
      wr(8'h5a + 4 * c, 8'h00);
    end
    // copy bits in all four combinations at unity gain
    for (int k = 0; k < 4; k++) begin
      wr(8'h5a, k[0] << 7);
      wr(8'h5e, k[1] << 7);
      smp($urandom, $urandom);
      chk("chan3", c3, k[0] ? m1 : m3);
      chk("chan4", c4, k[1] ? m2 : m4);
    end
    for (int i = 0; i < 10; i++) gchk(vt[i], tt[i], i % 2 ? -24'sh40000 : 24'sh40000);
    repeat (40) gchk($urandom % 256, $urandom % 16, $signed(24'($urandom)) >>> 3);
    wr(8'h57, 8'ha1);
    wr(8'h58, 8'h80);
    // delay line at a random depth and at the deepest setting
    for (int n = 0; n < 2; n++) begin
      int d;
      d = n ? 63 : 1 + $urandom % 62;
      wr(8'h59, d << 2);
      wr(8'h61, d << 2);
      repeat (64) smp($urandom, $urandom);
      repeat (8) begin
        smp($urandom, $urandom);
        chk("chan2 delayed", c2, hist[hist.size() - 1 - d]);
        chk("chan4 delayed", c4, hist[hist.size() - 1 - d]);
      end
    end
    complete_run;
  end
endmodule
bind acgp_channel_cfg acgp_monitor mon (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_hit(reg_hit), .mod_valid(mod_valid), .out_valid(out_valid),
  .chan2_sample(chan2_sample), .chan2_coupling_sel(chan2_coupling_sel),
  .chan2_range_sel(chan2_range_sel), .chan2_band_sel(chan2_band_sel));
